// ### apwc_pkg.sv
package apwc_pkg;
   // command codes
   localparam logic [7:0] CMD_SLEEP_A = 8'h99;
   localparam logic [7:0] CMD_SLEEP_B = 8'hE6;
   localparam logic [7:0] CMD_STBY_A = 8'h96;
   localparam logic [7:0] CMD_STBY_B = 8'hE2;
   localparam logic [7:0] CMD_STBYI_A = 8'h94;
   localparam logic [7:0] CMD_STBYI_B = 8'hE0;
   localparam logic [7:0] CMD_XLATE = 8'h87;
   localparam logic [7:0] CMD_WEAR = 8'hF5;
   localparam logic [7:0] CMD_WRBUF = 8'hE8;
   localparam logic [7:0] CMD_WRDMA = 8'hCA;
   localparam logic [7:0] CMD_SETFEAT = 8'hEF;
   localparam logic [7:0] FEAT_8BIT_ON = 8'h01;
   localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
   // sector-information block layout
   localparam logic [8:0] SI_CYL_HI = 9'h000;
   localparam logic [8:0] SI_CYL_LO = 9'h001;
   localparam logic [8:0] SI_HEAD = 9'h002;
   localparam logic [8:0] SI_SECT = 9'h003;
   localparam logic [8:0] SI_LBA_2 = 9'h004;
   localparam logic [8:0] SI_LBA_1 = 9'h005;
   localparam logic [8:0] SI_LBA_0 = 9'h006;
   localparam logic [8:0] SI_ERASED = 9'h013;
   localparam logic [8:0] SI_HOT_2 = 9'h018;
   localparam logic [8:0] SI_HOT_1 = 9'h019;
   localparam logic [8:0] SI_HOT_0 = 9'h01A;
   localparam logic [7:0] SI_ERASED_YES = 8'hFF;
   localparam logic [7:0] SI_ERASED_NO = 8'h00;
   localparam logic [7:0] WEAR_NOT_NEEDED = 8'h00;
   // sizes
   localparam int SECT_BYTES = 512;
   localparam int SECT_WORDS = SECT_BYTES / 2;
   localparam logic [8:0] MAX_SECTORS = 9'h100;
   // error register bit
   localparam int ERR_ABRT_BIT = 2;
   // timing
   localparam int CLK_HZ = 25000000;
   localparam int IDLE_MS = 5;
   localparam int IDLE_CYCLES = (CLK_HZ / 1000) * IDLE_MS;
   typedef enum logic [1:0] {APWC_PWR_ACTIVE, APWC_PWR_SLEEP} apwc_pwr_t;
endpackage

// ### apwc_buf_if.sv
interface apwc_buf_if;
   logic we;
   logic [7:0] waddr;
   logic [15:0] wdata;
   logic [7:0] raddr;
   logic [15:0] rdata;
   modport owner (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### apwc_sect_buf.sv
module apwc_sect_buf (
   // clock
   input wire logic clk_sys_i,
   // access
   apwc_buf_if.mem bus
);
   import apwc_pkg::*;
   logic [15:0] mem [0:SECT_WORDS-1];
   logic [15:0] rdata_r;

   // plain ram, no reset, so that it maps to block memory
   always_ff @(posedge clk_sys_i) begin
      if (bus.we) begin
         mem[bus.waddr] <= bus.wdata;
      end
      rdata_r <= mem[bus.raddr];
   end
   assign bus.rdata = rdata_r;
endmodule

// ### apwc_top.sv
// Summary of operation
// - sleep command: busy, enter sleep, drop busy, raise interrupt.
// - any new command wakes from sleep; reset also wakes but is never needed.
// - inactivity timer, default 5 ms, puts the card to sleep by itself.
// - standby: busy, sleep, clear busy, interrupt at once; later command wakes.
// - standby immediate behaves exactly like standby.
// - translate sector returns a 512 byte block describing the addressed sector.
// - bytes 0-1 cylinder high first, 2 head, 3 sector, 4-6 lba msb first.
// - byte 13h is FFh when sector erased, 00h otherwise.
// - bytes 18h-1Ah hold erase count msb first; other bytes reserved, zero.
// - without security, wear level is a no-op returning sector count zero.
// - with security, wear level code runs as a freeze-lock.
// - write buffer takes 512 bytes into the sector buffer, pio handshake.
// - dma write moves 1 to 256 sectors, zero means 256, from sector number.
// - dma write: busy and buffer preparation, drq optional.
// - dmareq held while the card can accept data.
// - dma write interrupts only at end or on unrecoverable error.
// - on success the address registers point at the last sector.
// - on error stop at failing sector, its address in the registers.
// - dma write with 8-bit mode enabled aborts.
// - features 01h/81h switch 8-bit mode; low byte lane only while on; here only write buffer honours it, translate read drives both lanes.
//
// Decided for this implementation: the strobed register port.
module apwc_top #(
   parameter int IDLE_COUNT = apwc_pkg::IDLE_CYCLES,
   parameter bit SECURITY_EN = 1'b0
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // task file from the decoder, same clock
   input wire logic cmd_wr_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] feature_i,
   input wire logic [7:0] sec_cnt_i,
   input wire logic [7:0] sec_num_i,
   input wire logic [15:0] cyl_i,
   input wire logic [3:0] head_i,
   input wire logic lba_mode_i,
   input wire logic drive_i,
   input wire logic drive_sel_i,
   // pio data port
   input wire logic pio_wr_i,
   input wire logic pio_rd_i,
   input wire logic [15:0] pio_wdata_i,
   output logic [15:0] pio_rdata_o,
   // dma pins, asynchronous
   input wire logic dmack_n_i,
   input wire logic iowr_n_i,
   input wire logic [15:0] dd_i,
   output logic dmareq_o,
   // media side
   input wire logic [23:0] hot_count_i,
   input wire logic erased_i,
   input wire logic media_err_i,
   output logic media_wr_o,
   // status back to the task file
   output logic busy_o,
   output logic drq_o,
   output logic intrq_o,
   output logic err_o,
   output logic [7:0] error_o,
   output logic [7:0] sec_cnt_o,
   output logic [7:0] sec_num_o,
   output logic [15:0] cyl_o,
   output logic [3:0] head_o,
   output logic sleep_o,
   output logic eight_bit_o,
   output logic frozen_o
);
   import apwc_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_PWR, ST_XLATE, ST_PIO_IN, ST_DMA, ST_DONE}
      apwc_state_t;

   apwc_state_t state_r;
   apwc_pwr_t pwr_r;
   logic [31:0] idle_cnt_r;
   logic [8:0] word_r;
   logic [8:0] sect_left_r;
   logic [7:0] sec_num_r;
   logic [15:0] cyl_r;
   logic [3:0] head_r;
   logic eight_bit_r;
   logic frozen_r;
   logic abort_r;
   logic mediaerr_r;
   logic [7:0] sc_out_r;
   logic intrq_r;
   logic [15:0] pio_rdata_r;
   logic [2:0] dmack_s, iowr_s;
   logic [15:0] dd_s1, dd_s2;
   logic iowr_prev_r;
   logic for_us;
   logic dma_word;
   logic cmd_go;

   apwc_buf_if buf_if ();
   apwc_sect_buf apwc_sect_buf_i (
      .clk_sys_i(clk_sys_i),
      .bus(buf_if)
   );

   function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] a,
                                    input logic [7:0] b);
      return (c == a) || (c == b);
   endfunction

   function automatic logic [8:0] sect_count(input logic [7:0] sc);
      return (sc == 8'h00) ? MAX_SECTORS : {1'b0, sc};
   endfunction

   // only drive select among the don't-care fields matters
   assign for_us = drive_i == drive_sel_i;
   assign cmd_go = cmd_wr_i && for_us;

   // dma pins: two flops before use; stage 0 feeds stage 1 only
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dmack_s <= 3'h7;
         iowr_s <= 3'h7;
         dd_s1 <= 16'h0000;
         dd_s2 <= 16'h0000;
      end else begin
         dmack_s <= {dmack_s[1:0], dmack_n_i};
         iowr_s <= {iowr_s[1:0], iowr_n_i};
         dd_s1 <= dd_i;
         dd_s2 <= dd_s1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         iowr_prev_r <= 1'b1;
      end else begin
         iowr_prev_r <= iowr_s[1];
      end
   end
   // word taken on the rising edge of the write strobe, with dmack low
   assign dma_word = (state_r == ST_DMA) && dmareq_o && !dmack_s[1]
                     && iowr_s[1] && !iowr_prev_r;

   // main sequencer
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
         word_r <= 9'h000;
         sect_left_r <= 9'h000;
         abort_r <= 1'b0;
         mediaerr_r <= 1'b0;
         sc_out_r <= 8'h00;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (cmd_go) begin
                  abort_r <= 1'b0;
                  mediaerr_r <= 1'b0;
                  word_r <= 9'h000;
                  sc_out_r <= sec_cnt_i;
                  if (is_cmd(cmd_i, CMD_SLEEP_A, CMD_SLEEP_B)
                      || is_cmd(cmd_i, CMD_STBY_A, CMD_STBY_B)
                      || is_cmd(cmd_i, CMD_STBYI_A, CMD_STBYI_B)) begin
                     state_r <= ST_PWR;
                  end else if (cmd_i == CMD_XLATE) begin
                     state_r <= ST_XLATE;
                  end else if (cmd_i == CMD_WEAR) begin
                     // no-op or freeze-lock, completes at once
                     sc_out_r <= WEAR_NOT_NEEDED;
                     state_r <= ST_DONE;
                  end else if (cmd_i == CMD_WRBUF) begin
                     state_r <= ST_PIO_IN;
                  end else if (cmd_i == CMD_WRDMA) begin
                     if (eight_bit_r) begin
                        abort_r <= 1'b1;
                        state_r <= ST_DONE;
                     end else begin
                        sect_left_r <= sect_count(sec_cnt_i);
                        state_r <= ST_DMA;
                     end
                  end else begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_PWR: begin
               state_r <= ST_DONE;
            end
            ST_XLATE: begin
               if (pio_rd_i) begin
                  word_r <= word_r + 9'h001;
                  if (word_r == 9'(SECT_WORDS - 1)) begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_PIO_IN: begin
               if (pio_wr_i) begin
                  word_r <= word_r + 9'h001;
                  if (word_r == 9'(SECT_WORDS - 1)) begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_DMA: begin
               if (media_err_i) begin
                  mediaerr_r <= 1'b1;
                  sc_out_r <= sect_left_r[7:0];
                  state_r <= ST_DONE;
               end else if (dma_word) begin
                  word_r <= word_r + 9'h001;
                  if (word_r == 9'(SECT_WORDS - 1)) begin
                     word_r <= 9'h000;
                     sect_left_r <= sect_left_r - 9'h001;
                     if (sect_left_r == 9'h001) begin
                        sc_out_r <= 8'h00;
                        state_r <= ST_DONE;
                     end
                  end
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // address registers follow the sector being written
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sec_num_r <= 8'h00;
         cyl_r <= 16'h0000;
         head_r <= 4'h0;
      end else if (state_r == ST_IDLE && cmd_go) begin
         sec_num_r <= sec_num_i;
         cyl_r <= cyl_i;
         head_r <= head_i;
      end else if (dma_word && word_r == 9'(SECT_WORDS - 1) && sect_left_r != 9'h001) begin
         // advance only when another sector follows, so the last or failing
         // sector stays in the registers
         sec_num_r <= sec_num_r + 8'h01;
      end
   end

   // 8-bit mode and freeze-lock
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         eight_bit_r <= 1'b0;
         frozen_r <= 1'b0;
      end else if (state_r == ST_IDLE && cmd_go) begin
         if (cmd_i == CMD_SETFEAT && feature_i == FEAT_8BIT_ON) begin
            eight_bit_r <= 1'b1;
         end else if (cmd_i == CMD_SETFEAT && feature_i == FEAT_8BIT_OFF) begin
            eight_bit_r <= 1'b0;
         end
         if (cmd_i == CMD_WEAR && SECURITY_EN) begin
            frozen_r <= 1'b1;
         end
      end
   end

   // power state and idle timer
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pwr_r <= APWC_PWR_ACTIVE;
         idle_cnt_r <= 32'h0000_0000;
      end else if (cmd_go) begin
         pwr_r <= APWC_PWR_ACTIVE;
         idle_cnt_r <= 32'h0000_0000;
      end else if (state_r == ST_PWR) begin
         pwr_r <= APWC_PWR_SLEEP;
      end else if (state_r != ST_IDLE || pio_rd_i || pio_wr_i) begin
         idle_cnt_r <= 32'h0000_0000;
      end else if (pwr_r == APWC_PWR_ACTIVE) begin
         if (idle_cnt_r >= 32'(IDLE_COUNT - 1)) begin
            pwr_r <= APWC_PWR_SLEEP;
            idle_cnt_r <= 32'h0000_0000;
         end else begin
            idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
         end
      end
   end

   // interrupt: set at completion, cleared by the next command
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         intrq_r <= 1'b0;
      end else if (state_r == ST_DONE) begin
         intrq_r <= 1'b1;
      end else if (cmd_go) begin
         intrq_r <= 1'b0;
      end
   end

   // sector buffer access
   always_comb begin
      buf_if.we = 1'b0;
      buf_if.wdata = 16'h0000;
      if (state_r == ST_PIO_IN && pio_wr_i) begin
         buf_if.we = 1'b1;
         // 8-bit mode uses the low lane only
         buf_if.wdata = eight_bit_r ? {8'h00, pio_wdata_i[7:0]} : pio_wdata_i;
      end else if (dma_word) begin
         buf_if.we = 1'b1;
         buf_if.wdata = dd_s2;
      end
   end
   assign buf_if.waddr = word_r[7:0];
   assign buf_if.raddr = 8'h00;

   // translate-sector block, built from live fields
   function automatic logic [7:0] si_byte(input logic [8:0] a);
      logic [7:0] b;
      b = 8'h00;
      case (a)
         SI_CYL_HI: b = cyl_r[15:8];
         SI_CYL_LO: b = cyl_r[7:0];
         SI_HEAD: b = {4'h0, head_r};
         SI_SECT: b = sec_num_r;
         SI_LBA_2: b = {4'h0, head_r};
         SI_LBA_1: b = cyl_r[15:8];
         SI_LBA_0: b = cyl_r[7:0];
         SI_ERASED: b = erased_i ? SI_ERASED_YES : SI_ERASED_NO;
         SI_HOT_2: b = hot_count_i[23:16];
         SI_HOT_1: b = hot_count_i[15:8];
         SI_HOT_0: b = hot_count_i[7:0];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // words are little-endian pairs: even byte on the low lane
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pio_rdata_r <= 16'h0000;
      end else if (state_r == ST_XLATE) begin
         pio_rdata_r <= {si_byte({word_r[7:0], 1'b1}), si_byte({word_r[7:0], 1'b0})};
      end else begin
         pio_rdata_r <= 16'h0000;
      end
   end

   assign dmareq_o = (state_r == ST_DMA) && !media_err_i;
   assign busy_o = state_r == ST_PWR || state_r == ST_DMA || state_r == ST_DONE;
   assign drq_o = state_r == ST_XLATE || state_r == ST_PIO_IN;
   assign intrq_o = intrq_r;
   assign err_o = abort_r || mediaerr_r;
   assign error_o = abort_r ? 8'(1 << ERR_ABRT_BIT) : 8'h00;
   assign sec_cnt_o = sc_out_r;
   assign sec_num_o = sec_num_r;
   assign cyl_o = cyl_r;
   assign head_o = head_r;
   assign sleep_o = pwr_r == APWC_PWR_SLEEP;
   assign eight_bit_o = eight_bit_r;
   assign frozen_o = frozen_r;
   assign pio_rdata_o = pio_rdata_r;
   assign media_wr_o = dma_word && word_r == 9'(SECT_WORDS - 1);

   sequence s_pwr_cmd;
      state_r == ST_IDLE && cmd_go && (is_cmd(cmd_i, CMD_SLEEP_A, CMD_SLEEP_B)
         || is_cmd(cmd_i, CMD_STBY_A, CMD_STBY_B) || is_cmd(cmd_i, CMD_STBYI_A, CMD_STBYI_B));
   endsequence
   sequence s_pwr_done;
      busy_o ##1 busy_o && sleep_o ##1 !busy_o && intrq_o && sleep_o;
   endsequence
   a_sleep_cmd_seq: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      s_pwr_cmd |=> s_pwr_done) else $error("power command sequence wrong");
   a_wake_on_cmd: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      cmd_go |=> !sleep_o) else $error("card stayed asleep after command");
   a_idle_no_sleep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (sleep_o == 1'b0 && $past(sleep_o) == 1'b0 && state_r == ST_IDLE && !cmd_go)
      |-> idle_cnt_r < 32'(IDLE_COUNT)) else $error("idle count overran");
   a_wear_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == ST_IDLE && cmd_go && cmd_i == CMD_WEAR) |=> ##1 sec_cnt_o == 8'h00)
      else $error("wear level count not zero");
   a_dma_8bit_abort: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == ST_IDLE && cmd_go && cmd_i == CMD_WRDMA && eight_bit_r)
      |=> !dmareq_o ##1 error_o[ERR_ABRT_BIT] && intrq_o) else $error("dma not aborted");
   a_dmareq_only_dma: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      dmareq_o |-> busy_o && state_r == ST_DMA) else $error("dmareq outside dma");
   a_dma_no_mid_irq: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == ST_DMA && $past(state_r) == ST_DMA) |-> !intrq_o)
      else $error("interrupt during dma");
   a_dma_count: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == ST_IDLE && cmd_go && cmd_i == CMD_WRDMA && !eight_bit_r)
      |=> sect_left_r == sect_count($past(sec_cnt_i))) else $error("dma count wrong");
   a_addr_hold_end: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == ST_DMA && sect_left_r == 9'h001) |=> $stable(sec_num_o))
      else $error("address moved past last sector");
endmodule

// ### apwc_host_model.sv
module apwc_host_model (
   // clock
   input wire logic clk_sys_i,
   // control from the bench
   input wire logic go_i,
   input wire logic slow_i,
   input wire logic [15:0] nwords_i,
   // dma pins
   input wire logic dmareq_i,
   output logic dmack_n_o,
   output logic iowr_n_o,
   output logic [15:0] dd_o,
   // progress
   output logic busy_o,
   output logic [15:0] sent_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      dmack_n_o = 1'b1;
      iowr_n_o = 1'b1;
      dd_o = 16'h5A5A;
      busy_o = 1'b0;
      sent_o = 16'h0000;
      forever begin
         @(posedge clk_sys_i);
         if (go_i) begin
            busy_o <= 1'b1;
            sent_o <= 16'h0000;
            run();
            busy_o <= 1'b0;
         end
      end
   end
   // one write strobe per word, only while the card requests; gives up if it stops asking
   task automatic run();
      int w;
      for (int i = 0; i < nwords_i; i++) begin
         w = 0;
         while (dmareq_i !== 1'b1 && w < 64) begin
            @(posedge clk_sys_i);
            w++;
         end
         if (w >= 64) break;
         dmack_n_o <= 1'b0;
         dd_o <= 16'(i) ^ 16'hC3A5;
         iowr_n_o <= 1'b0;
         repeat (3) @(posedge clk_sys_i);
         iowr_n_o <= 1'b1;
         // data held past the synchroniser; in slow mode then scrambled so stale values never match
         repeat (4) @(posedge clk_sys_i);
         sent_o <= sent_o + 16'h0001;
         if (slow_i) begin
            dmack_n_o <= 1'b1;
            dd_o <= ~dd_o;
            repeat (5) @(posedge clk_sys_i);
         end
      end
      dmack_n_o <= 1'b1;
      dd_o <= ~dd_o;
   endtask
endmodule

// ### apwc_top_bench.sv
module apwc_top_bench;
   import apwc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IDLE = 20;
   logic clk_sys_i = 1'b0, resetn_i = 1'b0, cmd_wr = 1'b0, lba = 1'b0, drv = 1'b0, dsel = 1'b0;
   logic [7:0] cmd = 8'h00, feat = 8'h00, cnt = 8'h00, snum = 8'h00;
   logic [15:0] cyl = 16'h1234, wdat = 16'h0000, dd, rdata, sent, cyl_q;
   logic [3:0] head = 4'h5, head_q;
   logic pio_wr = 1'b0, pio_rd = 1'b0, go = 1'b0, slow = 1'b0, merr = 1'b0, erased = 1'b1;
   logic [15:0] nwords = 16'h0000;
   logic [23:0] hot = 24'hABCDEF;
   logic dmack_n, iowr_n, dmareq, mwr, busy, drq, irq, err, sleep, eight, hbusy, frozen;
   logic [7:0] errv, cnt_o, num_o;
   int err_total = 0, n_checks = 0, mcnt = 0;
   initial forever #20 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (mwr === 1'b1) mcnt <= mcnt + 1;
   apwc_top #(.IDLE_COUNT(IDLE), .SECURITY_EN(1'b0)) apwc_top_i (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_wr_i(cmd_wr), .cmd_i(cmd),
      .feature_i(feat), .sec_cnt_i(cnt), .sec_num_i(snum), .cyl_i(cyl), .head_i(head),
      .lba_mode_i(lba), .drive_i(drv), .drive_sel_i(dsel), .pio_wr_i(pio_wr),
      .pio_rd_i(pio_rd), .pio_wdata_i(wdat), .pio_rdata_o(rdata), .dmack_n_i(dmack_n),
      .iowr_n_i(iowr_n), .dd_i(dd), .dmareq_o(dmareq), .hot_count_i(hot),
      .erased_i(erased), .media_err_i(merr), .media_wr_o(mwr), .busy_o(busy), .drq_o(drq),
      .intrq_o(irq), .err_o(err), .error_o(errv), .sec_cnt_o(cnt_o), .sec_num_o(num_o),
      .cyl_o(cyl_q), .head_o(head_q), .sleep_o(sleep), .eight_bit_o(eight), .frozen_o(frozen));
   apwc_host_model apwc_host_model_i (
      .clk_sys_i(clk_sys_i), .go_i(go), .slow_i(slow), .nwords_i(nwords), .dmareq_i(dmareq),
      .dmack_n_o(dmack_n), .iowr_n_o(iowr_n), .dd_o(dd), .busy_o(hbusy), .sent_o(sent));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic [7:0] n,
                        input logic [7:0] s);
      @(posedge clk_sys_i);
      cmd_wr <= 1'b1;
      cmd <= c;
      feat <= f;
      cnt <= n;
      snum <= s;
      @(posedge clk_sys_i);
      cmd_wr <= 1'b0;
   endtask
   // returns cycles taken; a miss is counted as a mismatch
   task automatic wait_irq(input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (irq !== 1'b1 && n < lim);
      chk(irq, 1'b1);
   endtask
   task automatic t_power();
      logic [7:0] pc[6] = '{CMD_SLEEP_A, CMD_SLEEP_B, CMD_STBY_A, CMD_STBY_B, CMD_STBYI_A,
                            CMD_STBYI_B};
      int n;
      foreach (pc[k]) begin
         issue(pc[k], 8'hFF, 8'hFF, 8'hFF);
         wait_irq(10, n);
         chk(n <= 4, 1'b1);
         chk({busy, sleep}, 2'b01);
         issue(CMD_WEAR, 8'h00, 8'h00, 8'h00);
         wait_irq(10, n);
         chk(sleep, 1'b0);
      end
      // a reset pulse wakes the card as well
      issue(CMD_SLEEP_B, 8'h00, 8'h00, 8'h00);
      wait_irq(10, n);
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      chk({sleep, irq, busy}, 3'b000);
   endtask
   task automatic t_wear_idle();
      int n;
      issue(CMD_WEAR, 8'hA5, 8'h3C, 8'h77);
      wait_irq(10, n);
      chk({err, cnt_o}, {1'b0, WEAR_NOT_NEEDED});
      chk(frozen, 1'b0);
      repeat (IDLE / 2) @(posedge clk_sys_i);
      chk(sleep, 1'b0);
      repeat (IDLE + 10) @(posedge clk_sys_i);
      chk(sleep, 1'b1);
   endtask
   function automatic logic [7:0] si_byte(input int a);
      case (a)
         0: return cyl[15:8];
         1: return cyl[7:0];
         2: return {4'h0, head};
         3: return 8'h2A;
         4: return {4'h0, head};
         5: return cyl[15:8];
         6: return cyl[7:0];
         19: return erased ? SI_ERASED_YES : SI_ERASED_NO;
         24: return hot[23:16];
         25: return hot[15:8];
         26: return hot[7:0];
         default: return 8'h00;
      endcase
   endfunction
   task automatic t_translate();
      int n;
      issue(CMD_XLATE, 8'h00, 8'h00, 8'h2A);
      n = 0;
      while (drq !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         n++;
      end
      for (int i = 0; i < SECT_WORDS; i++) begin
         repeat (2) @(posedge clk_sys_i);
         #1 chk(rdata, {si_byte(2 * i + 1), si_byte(2 * i)});
         if (i == 9) begin
            @(posedge clk_sys_i);
            erased <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
            #1 chk(rdata[15:8], SI_ERASED_NO);
            @(posedge clk_sys_i);
            erased <= 1'b1;
         end
         @(posedge clk_sys_i);
         pio_rd <= 1'b1;
         @(posedge clk_sys_i);
         pio_rd <= 1'b0;
      end
      repeat (4) @(posedge clk_sys_i);
      chk(drq, 1'b0);
   endtask
   task automatic t_wrbuf();
      int n;
      issue(CMD_WRBUF, 8'h00, 8'h00, 8'h00);
      repeat (3) @(posedge clk_sys_i);
      chk(drq, 1'b1);
      for (int i = 0; i < SECT_WORDS; i++) begin
         @(posedge clk_sys_i);
         pio_wr <= 1'b1;
         wdat <= 16'(i) ^ 16'h0F0F;
         @(posedge clk_sys_i);
         pio_wr <= 1'b0;
      end
      wait_irq(20, n);
      chk({busy, drq}, 2'b00);
      for (int i = 0; i < SECT_WORDS; i++) begin
         chk(apwc_top_i.apwc_sect_buf_i.mem[i], 16'(i) ^ 16'h0F0F);
      end
   endtask
   task automatic t_dma(input logic [7:0] ns, input logic [7:0] st, input bit fail);
      int n, base;
      base = mcnt;
      issue(CMD_WRDMA, 8'h00, ns, st);
      #1 chk({busy, dmareq}, 2'b11);
      go <= 1'b1;
      nwords <= 16'(ns) * 16'(SECT_WORDS);
      slow <= fail;
      @(posedge clk_sys_i);
      go <= 1'b0;
      if (fail) begin
         while (mcnt == base) @(posedge clk_sys_i);
         merr <= 1'b1;
      end
      wait_irq(8000, n);
      chk(mcnt - base, fail ? 1 : ns);
      chk(num_o, fail ? st + 8'h01 : st + ns - 8'h01);
      chk({err, dmareq}, {fail, 1'b0});
      if (fail) chk(cnt_o, ns - 8'h01);
      else chk(sent, 16'(ns) * 16'(SECT_WORDS));
      chk({cyl_q, head_q}, {cyl, head});
      if (!fail) begin
         for (int k = 0; k < SECT_WORDS; k++) begin
            chk(apwc_top_i.apwc_sect_buf_i.mem[k],
                16'((ns - 1) * SECT_WORDS + k) ^ 16'hC3A5);
         end
      end
      @(posedge clk_sys_i);
      merr <= 1'b0;
      n = 0;
      while (hbusy !== 1'b0 && n < 200) begin
         @(posedge clk_sys_i);
         n++;
      end
   endtask
   task automatic t_eight_bit();
      int n;
      issue(CMD_SETFEAT, FEAT_8BIT_ON, 8'h00, 8'h00);
      wait_irq(10, n);
      chk(eight, 1'b1);
      issue(CMD_WRDMA, 8'h00, 8'h01, 8'h00);
      wait_irq(10, n);
      chk({err, errv[ERR_ABRT_BIT], dmareq}, 3'b110);
      issue(CMD_SETFEAT, FEAT_8BIT_OFF, 8'h00, 8'h00);
      wait_irq(10, n);
      chk(eight, 1'b0);
      // other drive: must be ignored, previous completion stays visible
      @(posedge clk_sys_i);
      drv <= 1'b1;
      issue(CMD_SLEEP_A, 8'h00, 8'h00, 8'h00);
      repeat (3) @(posedge clk_sys_i);
      chk({busy, irq, sleep}, 3'b010);
      drv <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      t_power();
      t_wear_idle();
      t_translate();
      t_wrbuf();
      t_dma(8'h02, 8'h10, 1'b0);
      t_dma(8'h03, 8'h05, 1'b1);
      t_eight_bit();
      report_and_stop();
   end
endmodule
